// ==== verilog/pit_map.svh ====
// register offsets, control word fields, codes and reset values of the interval timer
`ifndef PIT_MAP_SVH
`define PIT_MAP_SVH

// ----------------------------------------------------------------
// byte offsets of the four timer locations
// ----------------------------------------------------------------
`define PIT_OFS_CNT0        8'h20
`define PIT_OFS_CNT1        8'h22
`define PIT_OFS_CNT2        8'h24
`define PIT_OFS_CTRL        8'h26

// ----------------------------------------------------------------
// control word field positions
// ----------------------------------------------------------------
`define PIT_CW_SEL_MSB      7
`define PIT_CW_SEL_LSB      6
`define PIT_CW_ACC_MSB      5
`define PIT_CW_ACC_LSB      4
`define PIT_CW_MODE_MSB     3
`define PIT_CW_MODE_MID     2
`define PIT_CW_MODE_LSB     1
`define PIT_CW_BCD          0

// ----------------------------------------------------------------
// access type and mode codes
// ----------------------------------------------------------------
`define PIT_ACC_LATCH       2'h0
`define PIT_ACC_LSB         2'h1
`define PIT_ACC_MSB         2'h2
`define PIT_ACC_BOTH        2'h3
`define PIT_MODE_0          3'h0
`define PIT_MODE_1          3'h1
`define PIT_MODE_2          3'h2
`define PIT_MODE_3          3'h3
`define PIT_MODE_4          3'h4
`define PIT_MODE_5          3'h5
`define PIT_FMT_BIN         1'b0
`define PIT_FMT_BCD         1'b1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PIT_RST_ACC         2'h3
`define PIT_RST_MODE        3'h0
`define PIT_RST_COUNT       16'h0000
`define PIT_RST_OUT         1'b0
`define PIT_RST_RDATA       8'h00

// ----------------------------------------------------------------
// timing: count clock limit against the 40 MHz system clock
// ----------------------------------------------------------------
`define PIT_SYS_CLK_KHZ     40000
`define PIT_CNT_CLK_MAX_KHZ 5000
`define PIT_CNT_CLK_MIN_CYC (`PIT_SYS_CLK_KHZ / `PIT_CNT_CLK_MAX_KHZ)

`endif

// ==== verilog/pit_pkg.sv ====
// types shared by the interval timer design files
`default_nettype none
package pit_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int PIT_NUM_CH = 3;
    localparam int PIT_CW     = 16;

    // ----------------------------------------------------------------
    // counting phase of one channel
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        PIT_PH_IDLE  = 3'b001,
        PIT_PH_ARMED = 3'b010,
        PIT_PH_RUN   = 3'b100
    } pit_phase_e;

    // ----------------------------------------------------------------
    // per channel state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0]        acc;
        logic [2:0]        mode;
        logic              bcd;
        logic [PIT_CW-1:0] cr;
        logic [PIT_CW-1:0] ce;
        logic [PIT_CW-1:0] ol;
        logic              latched;
        logic              wr_hi;
        logic              rd_hi;
        logic              trig;
        logic              out;
        logic              clk_q;
        logic              gate_q;
        pit_phase_e        phase;
    } pit_chan_s;

    typedef struct packed {
        pit_chan_s [PIT_NUM_CH-1:0] ch;
        logic [7:0]                 rdata;
    } pit_state_s;

endpackage
`default_nettype wire

// ==== verilog/pit_dec.sv ====
// count step unit: binary or four digit decimal decrement by one or two
`timescale 1ns/1ps
`default_nettype none
module pit_dec (
    input  wire logic [15:0] val_i,
    input  wire logic        bcd_i,
    input  wire logic [1:0]  step_i,
    output logic      [15:0] val_o
);

    // ----------------------------------------------------------------
    // digit-wise borrow chain; 0000 wraps to 9999 like 0 wraps to ffff
    // ----------------------------------------------------------------
    always_comb begin
        logic [4:0] d;
        logic [1:0] b;
        logic [15:0] r;
        d = 5'h00;
        b = step_i;
        r = 16'h0000;
        for (int k = 0; k < 4; k++) begin
            d = {1'b0, val_i[4*k +: 4]} - {3'h0, b};
            if (d[4]) begin
                r[4*k +: 4] = d[3:0] + 4'hA; // borrow from next digit
                b = 2'h1;
            end else begin
                r[4*k +: 4] = d[3:0];
                b = 2'h0;
            end
        end
        if (bcd_i) begin
            val_o = r;
        end else begin
            val_o = val_i - {14'h0, step_i};
        end
    end

endmodule // pit_dec
`default_nettype wire

// ==== verilog/pit_top.sv ====
// three channel interval timer with byte wide host port
//
// Overview of operation
// - three independent sixteen bit programmable counters
// - count clocks from static up to 5 MHz
// - six modes set by a control write
// - three data ports at successive even offsets
// - bits 7:6 select counter, 11 illegal
// - bits 5:4 latch, low, high or both
// - bits 3:1 select mode, bit 3 partly ignored
// - bit 0 selects binary or decimal counting
// - ranges 0 to 65535 or 0 to 9999
// - modes 0 to 5 with their behaviours
`include "pit_map.svh"
`timescale 1ns/1ps
`default_nettype none
module pit_top #(
    parameter int AW = 8
) (
    input  wire logic          clk_i,
    input  wire logic          rst_b_i,
    input  wire logic [AW-1:0] addr_i,
    input  wire logic          wr_i,
    input  wire logic          rd_i,
    input  wire logic [7:0]    wdata_i,
    output logic      [7:0]    rdata_o,
    input  wire logic [2:0]    cnt_clk_i,
    input  wire logic [2:0]    gate_i,
    output logic      [2:0]    out_o
);

    // ----------------------------------------------------------------
    // constants
    // ----------------------------------------------------------------
    localparam logic [AW-1:0] DATA_OFS [3] = '{
        AW'(`PIT_OFS_CNT0), AW'(`PIT_OFS_CNT1), AW'(`PIT_OFS_CNT2)
    };
    localparam logic [AW-1:0] CTRL_OFS = AW'(`PIT_OFS_CTRL);

    localparam pit_pkg::pit_chan_s CH_RST = '{
        acc:     `PIT_RST_ACC,
        mode:    `PIT_RST_MODE,
        bcd:     `PIT_FMT_BIN,
        cr:      `PIT_RST_COUNT,
        ce:      `PIT_RST_COUNT,
        ol:      `PIT_RST_COUNT,
        latched: 1'b0,
        wr_hi:   1'b0,
        rd_hi:   1'b0,
        trig:    1'b0,
        out:     `PIT_RST_OUT,
        clk_q:   1'b0,
        gate_q:  1'b1, // no false gate edge when the pin idles high
        phase:   pit_pkg::PIT_PH_IDLE
    };

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    pit_pkg::pit_state_s st;
    pit_pkg::pit_state_s next_st;
    logic [15:0]         ce_dec [3];

    // ----------------------------------------------------------------
    // one step unit per channel; mode 3 steps by two
    // ----------------------------------------------------------------
    for (genvar g = 0; g < pit_pkg::PIT_NUM_CH; g++) begin : g_ch
        pit_dec u_dec (
            .val_i  (st.ch[g].ce),
            .bcd_i  (st.ch[g].bcd),
            .step_i ((st.ch[g].mode == `PIT_MODE_3) ? 2'h2 : 2'h1),
            .val_o  (ce_dec[g])
        );
        assign out_o[g] = st.ch[g].out; // straight from the flop
    end

    assign rdata_o = st.rdata;

    // ----------------------------------------------------------------
    // next state: counting, then host writes, then host reads
    // ----------------------------------------------------------------
    always_comb begin
        pit_pkg::pit_chan_s c;
        logic               cedge;
        logic               gate_ok;
        logic               trig_mode;
        logic               load;
        logic               one;
        logic [2:0]         nmode;
        logic [15:0]        lv;
        logic [15:0]        src;
        c         = CH_RST;
        cedge     = 1'b0;
        gate_ok   = 1'b0;
        trig_mode = 1'b0;
        load      = 1'b0;
        one       = 1'b0;
        nmode     = `PIT_MODE_0;
        lv        = 16'h0000;
        src       = 16'h0000;
        next_st   = st;
        // reads of the control or an unmapped location answer zero
        if (rd_i) begin
            next_st.rdata = `PIT_RST_RDATA;
        end
        for (int i = 0; i < pit_pkg::PIT_NUM_CH; i++) begin
            c = st.ch[i];
            // count clock arrives synchronous; a rising edge is one tick,
            // which holds while it stays at or below half of the system rate
            cedge     = cnt_clk_i[i] & ~c.clk_q;
            c.clk_q   = cnt_clk_i[i];
            c.gate_q  = gate_i[i];
            trig_mode = (c.mode == `PIT_MODE_1) || (c.mode == `PIT_MODE_5);
            gate_ok   = trig_mode | gate_i[i];
            one       = (c.ce == 16'h0001);
            // mode 3 reloads even so that both half periods stay whole
            lv = (c.mode == `PIT_MODE_3) ? {c.cr[15:1], 1'b0} : c.cr;
            if (gate_i[i] & ~st.ch[i].gate_q) begin
                c.trig = 1'b1;
            end
            // rate generators hold the output high while gated off
            if (!gate_i[i] && (c.mode == `PIT_MODE_2 || c.mode == `PIT_MODE_3)) begin
                c.out = 1'b1;
            end
            if (cedge) begin
                case (c.phase)
                    pit_pkg::PIT_PH_IDLE: begin
                        c.trig = 1'b0;
                    end
                    pit_pkg::PIT_PH_ARMED: begin
                        if (!trig_mode || c.trig) begin
                            c.ce    = lv;
                            c.phase = pit_pkg::PIT_PH_RUN;
                            c.trig  = 1'b0;
                            if (c.mode == `PIT_MODE_1) begin
                                c.out = 1'b0;
                            end
                        end
                    end
                    pit_pkg::PIT_PH_RUN: begin
                        if (c.trig && c.mode != `PIT_MODE_0 && c.mode != `PIT_MODE_4) begin
                            // gate edge restarts the period from the count register
                            c.ce   = lv;
                            c.trig = 1'b0;
                            c.out  = (c.mode != `PIT_MODE_1);
                        end else if (gate_ok) begin
                            c.trig = 1'b0;
                            case (c.mode)
                                `PIT_MODE_0, `PIT_MODE_1: begin
                                    c.ce = ce_dec[i];
                                    if (one) begin
                                        c.out = 1'b1;
                                    end
                                end
                                `PIT_MODE_2: begin
                                    if (one) begin
                                        c.ce  = lv;
                                        c.out = 1'b1;
                                    end else begin
                                        c.ce = ce_dec[i];
                                        if (c.ce == 16'h0001) begin
                                            c.out = 1'b0;
                                        end
                                    end
                                end
                                `PIT_MODE_3: begin
                                    if (c.ce == 16'h0002) begin
                                        c.ce  = lv;
                                        c.out = ~c.out;
                                    end else begin
                                        c.ce = ce_dec[i];
                                    end
                                end
                                `PIT_MODE_4, `PIT_MODE_5: begin
                                    c.ce = ce_dec[i];
                                    if (one) begin
                                        c.out = 1'b0;
                                    end else if (!c.out) begin
                                        // strobe done; mode 5 waits for the next gate edge
                                        c.out   = 1'b1;
                                        c.phase = (c.mode == `PIT_MODE_5) ?
                                                  pit_pkg::PIT_PH_ARMED :
                                                  pit_pkg::PIT_PH_IDLE;
                                    end
                                end
                                default: begin
                                    c.phase = pit_pkg::PIT_PH_IDLE;
                                end
                            endcase
                        end
                    end
                    default: begin
                        c.phase = pit_pkg::PIT_PH_IDLE;
                    end
                endcase
            end

            // control word; select code 11 matches no channel and is dropped
            if (wr_i && addr_i == CTRL_OFS &&
                wdata_i[`PIT_CW_SEL_MSB:`PIT_CW_SEL_LSB] == 2'(i)) begin
                if (wdata_i[`PIT_CW_ACC_MSB:`PIT_CW_ACC_LSB] == `PIT_ACC_LATCH) begin
                    // a second latch before the read is ignored
                    if (!c.latched) begin
                        c.ol      = c.ce;
                        c.latched = 1'b1;
                    end
                end else begin
                    // bit 3 is a don't care once bit 2 is set
                    nmode = wdata_i[`PIT_CW_MODE_MID] ?
                            {1'b0, wdata_i[`PIT_CW_MODE_MID:`PIT_CW_MODE_LSB]} :
                            wdata_i[`PIT_CW_MODE_MSB:`PIT_CW_MODE_LSB];
                    c.acc     = wdata_i[`PIT_CW_ACC_MSB:`PIT_CW_ACC_LSB];
                    c.mode    = nmode;
                    c.bcd     = (wdata_i[`PIT_CW_BCD] == `PIT_FMT_BCD);
                    c.wr_hi   = 1'b0;
                    c.rd_hi   = 1'b0;
                    c.latched = 1'b0;
                    c.trig    = 1'b0;
                    c.phase   = pit_pkg::PIT_PH_IDLE;
                    c.out     = (nmode != `PIT_MODE_0);
                end
            end

            // count writes into the data port
            load = 1'b0;
            if (wr_i && addr_i == DATA_OFS[i]) begin
                case (c.acc)
                    `PIT_ACC_LSB: begin
                        c.cr = {8'h00, wdata_i};
                        load = 1'b1;
                    end
                    `PIT_ACC_MSB: begin
                        c.cr = {wdata_i, 8'h00};
                        load = 1'b1;
                    end
                    `PIT_ACC_BOTH: begin
                        if (!c.wr_hi) begin
                            c.cr[7:0] = wdata_i;
                            c.wr_hi   = 1'b1;
                            if (c.mode == `PIT_MODE_0) begin
                                // half a count stops mode 0 until the rest arrives
                                c.out   = 1'b0;
                                c.phase = pit_pkg::PIT_PH_IDLE;
                            end
                        end else begin
                            c.cr[15:8] = wdata_i;
                            c.wr_hi    = 1'b0;
                            load       = 1'b1;
                        end
                    end
                    default: begin
                        load = 1'b0;
                    end
                endcase
            end
            if (load) begin
                // running periodic and triggered modes pick the count up at
                // their next reload, so they keep running
                if (c.phase != pit_pkg::PIT_PH_RUN ||
                    c.mode == `PIT_MODE_0 || c.mode == `PIT_MODE_4) begin
                    c.phase = pit_pkg::PIT_PH_ARMED;
                    c.trig  = 1'b0;
                end
                if (c.mode == `PIT_MODE_0) begin
                    c.out = 1'b0;
                end
            end

            // data port reads: latched value first, else the live count
            if (rd_i && addr_i == DATA_OFS[i]) begin
                src = st.ch[i].latched ? st.ch[i].ol : st.ch[i].ce;
                case (c.acc)
                    `PIT_ACC_LSB: begin
                        next_st.rdata = src[7:0];
                        c.latched     = c.latched & ~st.ch[i].latched; // new latch survives
                    end
                    `PIT_ACC_MSB: begin
                        next_st.rdata = src[15:8];
                        c.latched     = c.latched & ~st.ch[i].latched;
                    end
                    `PIT_ACC_BOTH: begin
                        next_st.rdata = c.rd_hi ? src[15:8] : src[7:0];
                        if (c.rd_hi && st.ch[i].latched) begin
                            c.latched = 1'b0;
                        end
                        c.rd_hi = ~c.rd_hi;
                    end
                    default: begin
                        next_st.rdata = src[7:0];
                    end
                endcase
            end
            next_st.ch[i] = c;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st <= '{ch: '{CH_RST, CH_RST, CH_RST}, rdata: `PIT_RST_RDATA};
        end else begin
            st <= next_st;
        end
    end

endmodule // pit_top
`default_nettype wire

// ==== sim/pit_monitor.sv ====
// port checker of the interval timer
`include "pit_map.svh"
`timescale 1ns/1ps
`default_nettype none
module pit_monitor #(
    parameter int AW = 8
) (
    input  wire logic          clk_i,
    input  wire logic          rst_b_i,
    input  wire logic [AW-1:0] addr_i,
    input  wire logic          wr_i,
    input  wire logic          rd_i,
    input  wire logic [7:0]    wdata_i,
    input  wire logic [7:0]    rdata_o,
    input  wire logic [2:0]    cnt_clk_i,
    input  wire logic [2:0]    gate_i,
    input  wire logic [2:0]    out_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    // ----------------------------------------------------------------
    // named steps
    // ----------------------------------------------------------------
    // legal control write that is not a latch command
    sequence s_ctrl;
        wr_i && addr_i == `PIT_OFS_CTRL && wdata_i[7:6] != 2'h3 && wdata_i[5:4] != 2'h0;
    endsequence
    // no count clock on the masked channels for three cycles
    sequence s_noclk(logic [2:0] m);
        ((cnt_clk_i & m) == 3'h0 && $stable(gate_i)) [*3];
    endsequence

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    AST_RD_HOLD: assert property (!rd_i |=> $stable(rdata_o))
        else $error("read data moved without a read");
    AST_RD_NONDATA: assert property (rd_i && addr_i != `PIT_OFS_CNT0 && addr_i != `PIT_OFS_CNT1
        && addr_i != `PIT_OFS_CNT2 |=> rdata_o == `PIT_RST_RDATA)
        else $error("non data location read nonzero");
    AST_CTRL_M0: assert property (s_ctrl ##0 wdata_i[3:1] == 3'h0
        |=> out_o[$past(wdata_i[7:6])] == 1'b0)
        else $error("mode 0 control did not drive out low");
    AST_CTRL_HI: assert property (s_ctrl ##0 wdata_i[3:1] != 3'h0
        |=> out_o[$past(wdata_i[7:6])] == 1'b1)
        else $error("non zero mode control did not drive out high");
    AST_BAD_SEL: assert property (s_noclk(3'h7) ##0 (wr_i && addr_i == `PIT_OFS_CTRL
        && wdata_i[7:6] == 2'h3) |=> $stable(out_o))
        else $error("illegal select changed a counter");
    AST_IDLE_STABLE: assert property (s_noclk(3'h7) ##0 !wr_i |=> $stable(out_o))
        else $error("out moved with static count clocks");
    AST_INDEP: assert property (s_noclk(3'h6) ##0 !wr_i |=> $stable(out_o[2:1]))
        else $error("channel 1 or 2 moved on another channel clock");
    AST_M0_HOLD: assert property (s_ctrl ##0 wdata_i[7:1] == 7'h18 ##1
        (cnt_clk_i[0] == 1'b0 && !wr_i) [*2] |=> !out_o[0])
        else $error("mode 0 out rose without count ticks");
endmodule // pit_monitor
`default_nettype wire

// ==== sim/pit_host_bfm.sv ====
// host bus model issuing byte reads and writes
`include "pit_map.svh"
`timescale 1ns/1ps
`default_nettype none
module pit_host_bfm (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output var  logic [7:0] addr_o,
    output var  logic       wr_o,
    output var  logic       rd_o,
    output var  logic [7:0] wdata_o
);
    // idle bus at time zero
    initial begin
        addr_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 8'h00;
    end
    // released lines show the inverse so a stale value cannot pass
    task automatic drop();
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = ~addr_o;
        wdata_o = ~wdata_o;
    endtask
    // one byte write, strobe held for one clock
    task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clk_i);
        drop();
    endtask
    // one byte read, data taken the cycle after the strobe
    task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clk_i);
        drop();
        d = rdata_i;
    endtask
    // control word for a legal channel, issued before any count access
    task automatic ctrl(input logic [1:0] ch, input logic [1:0] acc,
                        input logic [2:0] md, input logic bcd);
        wr_byte(`PIT_OFS_CTRL, {ch, acc, md, bcd});
    endtask
endmodule // pit_host_bfm
`default_nettype wire

// ==== sim/test_three_channel_interval_timer.sv ====
// self-checking bench of the interval timer
`include "pit_map.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("wrong value at %0t: %s", $time, msg); \
    end \
end
module test_three_channel_interval_timer;
    logic       clk_i = 1'b0;
    logic       rst_b_i = 1'b0;
    logic [7:0] addr_i, wdata_i, rdata_o;
    logic       wr_i, rd_i;
    logic [2:0] cnt_clk_i = 3'h0;
    logic [2:0] gate_i = 3'h7;
    logic [2:0] out_o;
    int         mismatches = 0;
    int         n_tests = 0;
    int         cyc = 0;
    int         i;

    always #12.5 clk_i = ~clk_i;

    pit_host_bfm host_u (.clk_i(clk_i), .rdata_i(rdata_o), .addr_o(addr_i), .wr_o(wr_i),
                         .rd_o(rd_i), .wdata_o(wdata_i));
    pit_top #(.AW(8)) dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wr_i(wr_i),
                             .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
                             .cnt_clk_i(cnt_clk_i), .gate_i(gate_i), .out_o(out_o));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // one count tick at the fastest allowed rate, 4 cycles high and 4 low
    task automatic tick(input int ch);
        @(negedge clk_i);
        cnt_clk_i[ch] = 1'b1;
        repeat (4) @(negedge clk_i);
        cnt_clk_i[ch] = 1'b0;
        repeat (4) @(negedge clk_i);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string msg);
        logic [7:0] d;
        host_u.rd_byte(a, d);
        `CHK(d, exp, msg)
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // hang guard, the tests need well under a thousand cycles
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            $display("wrong value at %0t: run did not finish", $time);
            summarize();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (3) @(negedge clk_i);
        `CHK(out_o, `PIT_RST_OUT ? 3'h7 : 3'h0, "reset out")
        `CHK(rdata_o, `PIT_RST_RDATA, "reset read data")
        rst_b_i = 1'b1;
        // every mode code, 6 and 7 fold onto 2 and 3
        for (i = 0; i < 8; i++) begin
            host_u.ctrl(2'h0, 2'h3, i[2:0], 1'b0);
            repeat (3) @(negedge clk_i);
            `CHK(out_o[0], (i != 0), "out level after control")
        end
        $display("test mode codes done");
        // mode 0, count 3 in two bytes, low byte first
        host_u.ctrl(2'h0, 2'h3, 3'h0, 1'b0);
        host_u.wr_byte(`PIT_OFS_CNT0, 8'h03);
        host_u.wr_byte(`PIT_OFS_CNT0, 8'h00);
        for (i = 0; i < 3; i++) begin
            tick(0);
            `CHK(out_o[0], 1'b0, "mode 0 early terminal")
        end
        tick(0);
        `CHK(out_o[0], 1'b1, "mode 0 terminal count")
        // illegal select must touch no channel
        host_u.wr_byte(`PIT_OFS_CTRL, 8'hF0);
        `CHK(out_o, 3'h1, "illegal select mode 0")
        host_u.wr_byte(`PIT_OFS_CTRL, 8'hF2);
        `CHK(out_o, 3'h1, "illegal select mode 1")
        $display("test mode 0 and select done");
        // latch holds a snapshot while the live count moves on
        host_u.ctrl(2'h2, 2'h3, 3'h0, 1'b0);
        host_u.wr_byte(`PIT_OFS_CNT2, 8'h34);
        host_u.wr_byte(`PIT_OFS_CNT2, 8'h12);
        tick(2);
        tick(2);
        host_u.ctrl(2'h2, 2'h0, 3'h0, 1'b0);
        tick(2);
        rd_chk(`PIT_OFS_CNT2, 8'h33, "latched low");
        rd_chk(`PIT_OFS_CNT2, 8'h12, "latched high");
        rd_chk(`PIT_OFS_CNT2, 8'h32, "live low");
        rd_chk(`PIT_OFS_CNT2, 8'h12, "live high");
        $display("test latch done");
        // count 0 wraps to the top of the range in each format
        for (i = 0; i < 2; i++) begin
            host_u.ctrl(2'h1, 2'h3, 3'h0, i[0]);
            host_u.wr_byte(`PIT_OFS_CNT1, 8'h00);
            host_u.wr_byte(`PIT_OFS_CNT1, 8'h00);
            tick(1);
            tick(1);
            rd_chk(`PIT_OFS_CNT1, i[0] ? 8'h99 : 8'hFF, "range low");
            rd_chk(`PIT_OFS_CNT1, i[0] ? 8'h99 : 8'hFF, "range high");
        end
        $display("test formats done");
        // single byte access kinds never alternate
        host_u.ctrl(2'h1, 2'h1, 3'h0, 1'b0);
        host_u.wr_byte(`PIT_OFS_CNT1, 8'h07);
        tick(1);
        rd_chk(`PIT_OFS_CNT1, 8'h07, "low only first");
        rd_chk(`PIT_OFS_CNT1, 8'h07, "low only second");
        host_u.ctrl(2'h1, 2'h2, 3'h0, 1'b0);
        host_u.wr_byte(`PIT_OFS_CNT1, 8'h56);
        tick(1);
        rd_chk(`PIT_OFS_CNT1, 8'h56, "high only");
        // control and unmapped places read as zero
        rd_chk(`PIT_OFS_CTRL, 8'h00, "control read");
        host_u.wr_byte(8'h21, 8'h5A);
        rd_chk(8'h21, 8'h00, "unmapped read");
        $display("test access kinds done");
        // mode 2 through code 110, period of 3 ticks with one low tick
        host_u.ctrl(2'h0, 2'h1, 3'h6, 1'b0);
        host_u.wr_byte(`PIT_OFS_CNT0, 8'h03);
        for (i = 0; i < 6; i++) begin
            tick(0);
            `CHK(out_o[0], ((i % 3) != 2), "rate generator out")
        end
        $display("test rate generator done");
        // mode 5 waits for a gate edge, then strobes low for one tick
        host_u.ctrl(2'h1, 2'h1, 3'h5, 1'b0);
        host_u.wr_byte(`PIT_OFS_CNT1, 8'h02);
        tick(1);
        gate_i[1] = 1'b0;
        @(negedge clk_i);
        gate_i[1] = 1'b1;
        for (i = 0; i < 4; i++) begin
            tick(1);
            `CHK(out_o[1], (i != 2), "hardware strobe out")
        end
        $display("test hardware strobe done");
        summarize();
    end
endmodule // test_three_channel_interval_timer
bind pit_top pit_monitor #(.AW(AW)) mon_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
    .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .cnt_clk_i(cnt_clk_i),
    .gate_i(gate_i), .out_o(out_o));
`default_nettype wire
